// File: core/rfc_fifo_cmd.sv
// FIFO, transmit-length registers and direct-command decoder of the reader.
// Assumes an AXI4-Lite master on clk_in and coder, framer and ADC logic
// on the same clock; only the enable pin is asynchronous.
//
// Overview of operation
// - In reception, status bit 7 rises once 18 bytes sit in the FIFO.
// - In transmission, status bit 6 rises when six or fewer bytes remain.
// - Status bit 5 flags a write into an already full FIFO.
// - Status bits 4..0 give the count of unread FIFO bytes.
// - FIFO status is zero during power-on reset or enable low.
// - Complete-byte count is 12 bits over the two length registers.
// - First length register clears at end of transmit frame and resets.
// - Length bit 0 flags a broken last byte; bits 3..1 its bits.
// - Second length register is write-only for transmission.
// - Its read bits 4..0 show valid bits of last received byte.
// - The 24-byte FIFO sits behind one data address, used cyclically.
// - Commands carry MSB one; code 80 is idle.
// - Command 83 clears the block like power-on reset, but not the bus handshake.
// - Command 84 selects main divider, 85 auxiliary divider.
// - Command 87 starts an 8-bit conversion into the ADC register.
// - Select 001/010 route mixer levels, 011 the external input pin.
// - Command 8F clears FIFO pointers, interrupt flags, collision location.
// - Transmit starts on third payload byte or complete shorter payload.
// - 90 sends with CRC-16, 91 also expects header, 92 without CRC.
// - 98 sends Query with CRC-5 no RX CRC; 99 QueryRep without CRCs.
`timescale 1ns/1ps
module rfc_fifo_cmd #(
	parameter int DEPTH = rfc_pkg::RFC_FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic en_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic tx_start_out,
	output logic [7:0] tx_cmd_out,
	output rfc_pkg::rfc_crc_e tx_crc_out,
	output logic tx_header_exp_out,
	output logic rx_crc_check_out,
	output logic [11:0] tx_byte_count_out,
	output logic tx_partial_flag_out,
	output logic [2:0] tx_partial_bits_out,
	output logic [7:0] tx_data_out,
	output logic tx_data_valid_out,
	input wire logic tx_data_ready_in,
	input wire logic tx_eof_in,
	input wire logic rx_active_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_data_valid_in,
	input wire logic rx_done_in,
	input wire logic [4:0] rx_last_bits_in,
	output logic pll_aux_sel_out,
	output logic adc_start_out,
	output logic [2:0] adc_msel_out,
	input wire logic [7:0] adc_result_in,
	input wire logic adc_done_in,
	output logic fifo_clear_out,
	output logic soft_init_out
);
	import rfc_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// ==========================================================
	// Enable pin synchroniser
	logic [2:0] en_s_ff;
	logic en_lvl_ff;
	logic soft_ff;
	logic clr;

	// Level accepted only once the two later stages agree
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_s_ff <= 3'h0;
			en_lvl_ff <= 1'b0;
		end else begin
			en_s_ff <= {en_s_ff[1:0], en_in};
			if (en_s_ff[1] == en_s_ff[2]) begin
				en_lvl_ff <= en_s_ff[2];
			end
		end
	end

	// Soft init and enable low clear the block, not the bus handshake
	assign clr = soft_ff | ~en_lvl_ff;

	// ==========================================================
	// AXI4-Lite handshake registers
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_full_ff, w_full_ff;
	logic [5:0] aw_idx_ff;
	logic [7:0] w_byte_ff;
	logic w_lane_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic aw_take, w_take, ar_take, wr_fire, b_done, r_done;

	assign aw_take = s_axi_awvalid_in & awready_ff;
	assign w_take = s_axi_wvalid_in & wready_ff;
	assign ar_take = s_axi_arvalid_in & arready_ff;
	assign wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
	assign b_done = bvalid_ff & s_axi_bready_in;
	assign r_done = rvalid_ff & s_axi_rready_in;

	// ==========================================================
	// Write decode
	logic wr_stat, wr_high, wr_low, wr_data, wr_cmd, wr_ctrl, wr_ro, wr_ok;
	logic push_host, cmd_go;
	logic [7:0] cmd;

	assign wr_stat = aw_idx_ff == RFC_IDX_FIFO_STAT;
	assign wr_high = aw_idx_ff == RFC_IDX_TX_LEN_HIGH;
	assign wr_low = aw_idx_ff == RFC_IDX_TX_LEN_LOW;
	assign wr_data = aw_idx_ff == RFC_IDX_FIFO_DATA;
	assign wr_cmd = aw_idx_ff == RFC_IDX_CMD;
	assign wr_ctrl = aw_idx_ff == RFC_IDX_CTRL;
	assign wr_ro = wr_stat | (aw_idx_ff == RFC_IDX_ADC_VAL) |
		(aw_idx_ff == RFC_IDX_STATE);
	assign wr_ok = wr_high | wr_low | wr_data | wr_cmd | wr_ctrl | wr_ro;
	// Writes do nothing while the block is held clear
	assign push_host = wr_fire & wr_data & w_lane_ff & ~clr;
	assign cmd = w_byte_ff;
	// Codes with the MSB low are not commands and are dropped
	assign cmd_go = wr_fire & wr_cmd & w_lane_ff & ~clr & cmd[RFC_CMD_BIT];

	// Write channel: address and data taken in either order
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			aw_idx_ff <= 6'h00;
			w_byte_ff <= 8'h00;
			w_lane_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RFC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				awready_ff <= 1'b0;
				aw_full_ff <= 1'b1;
				aw_idx_ff <= s_axi_awaddr_in[7:2];
			end
			if (w_take) begin
				wready_ff <= 1'b0;
				w_full_ff <= 1'b1;
				w_byte_ff <= s_axi_wdata_in[7:0];
				w_lane_ff <= s_axi_wstrb_in[0];
			end
			if (wr_fire) begin
				aw_full_ff <= 1'b0;
				w_full_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? RFC_RESP_OKAY : RFC_RESP_SLVERR;
			end else if (b_done) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Command decode
	logic c_soft, c_main, c_aux, c_adc, c_frst, c_txd, c_txi;

	assign c_soft = cmd_go & (cmd == RFC_CMD_SOFT_INIT);
	assign c_main = cmd_go & (cmd == RFC_CMD_HOP_MAIN);
	assign c_aux = cmd_go & (cmd == RFC_CMD_HOP_AUX);
	assign c_adc = cmd_go & (cmd == RFC_CMD_ADC);
	assign c_frst = cmd_go & (cmd == RFC_CMD_FIFO_RST);
	// Payload-carrying transmits wait for FIFO data
	assign c_txd = cmd_go & (cmd == RFC_CMD_TX_CRC || cmd == RFC_CMD_TX_HDR ||
		cmd == RFC_CMD_TX_NOCRC || cmd == RFC_CMD_QUERY);
	// Gen2 short commands carry no host payload and start at once
	assign c_txi = cmd_go & (cmd >= RFC_CMD_QREP) & (cmd <= RFC_CMD_REQRN);

	// ==========================================================
	// FIFO storage and pointers
	logic [7:0] mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic ovf_ff;
	logic full, empty, rx_push, push, pop_host, pop_tx, pop;
	logic rd_data_hit;
	rfc_tx_e tx_st_ff;

	assign full = count_ff == CW'(DEPTH);
	assign empty = count_ff == '0;
	// Host write wins a same-cycle clash; the framer byte is then lost
	assign rx_push = rx_data_valid_in & rx_active_in & ~push_host & ~clr;
	assign push = (push_host | rx_push) & ~full;
	assign pop_tx = (tx_st_ff == RFC_TX_RUN) & ~empty & ~clr &
		(~tx_data_valid_out | tx_data_ready_in);
	assign rd_data_hit = s_axi_araddr_in[7:2] == RFC_IDX_FIFO_DATA;
	// Coder drain has priority; a host read then returns the head unpopped
	assign pop_host = ar_take & rd_data_hit & ~empty & ~pop_tx & ~clr;
	assign pop = pop_tx | pop_host;

	// One entry per FIFO slot, written at the write pointer
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				mem_ff[i] <= 8'h00;
			end else if (push && wr_ptr_ff == PW'(i)) begin
				mem_ff[i] <= push_host ? w_byte_ff : rx_data_in;
			end
		end
	end

	// Cyclic pointers, unread count and sticky overflow
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ovf_ff <= 1'b0;
		end else if (clr || c_frst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ovf_ff <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
			if ((push_host | rx_push) && full) begin
				ovf_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Length, control and converter registers
	logic [7:0] tx_high_ff, tx_low_ff, adc_val_ff;
	logic [4:0] rx_bits_ff;
	logic [2:0] msel_ff;
	logic pll_aux_ff, adc_start_ff, fifo_clr_ff;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_high_ff <= RFC_REG_RESET;
			tx_low_ff <= RFC_REG_RESET;
			rx_bits_ff <= 5'h00;
			msel_ff <= RFC_MSEL_RESET;
			adc_val_ff <= RFC_REG_RESET;
			pll_aux_ff <= 1'b0;
		end else if (clr) begin
			tx_high_ff <= RFC_REG_RESET;
			tx_low_ff <= RFC_REG_RESET;
			rx_bits_ff <= 5'h00;
			msel_ff <= RFC_MSEL_RESET;
			adc_val_ff <= RFC_REG_RESET;
			pll_aux_ff <= 1'b0;
		end else begin
			// Frame end wins over a host write in the same cycle
			if (tx_eof_in) begin
				tx_high_ff <= RFC_REG_RESET;
			end else if (wr_fire && wr_high && w_lane_ff) begin
				tx_high_ff <= w_byte_ff;
			end
			if (wr_fire && wr_low && w_lane_ff) begin
				tx_low_ff <= w_byte_ff;
			end
			if (rx_done_in) begin
				rx_bits_ff <= rx_last_bits_in;
			end
			if (wr_fire && wr_ctrl && w_lane_ff) begin
				msel_ff <= w_byte_ff[2:0];
			end
			if (adc_done_in) begin
				adc_val_ff <= adc_result_in;
			end
			if (c_aux) begin
				pll_aux_ff <= 1'b1;
			end else if (c_main) begin
				pll_aux_ff <= 1'b0;
			end
		end
	end

	// Command pulses; soft init is kept out of clr so it ends itself
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			soft_ff <= 1'b0;
			adc_start_ff <= 1'b0;
			fifo_clr_ff <= 1'b0;
		end else begin
			soft_ff <= c_soft;
			adc_start_ff <= c_adc;
			fifo_clr_ff <= c_frst;
		end
	end

	// ==========================================================
	// Transmit sequencer
	logic [12:0] need, loaded_ff;
	logic go_now, start;
	logic tx_start_ff, hdr_ff, rx_crc_ff, tx_valid_ff, part_flag_ff;
	logic [7:0] tx_cmd_ff, tx_data_ff;
	logic [11:0] tx_count_ff;
	logic [2:0] part_bits_ff;
	rfc_crc_e crc_ff;

	// Payload length counts a broken last byte as one more byte
	assign need = (tx_cmd_ff == RFC_CMD_QUERY) ? 13'(RFC_QUERY_BYTES) :
		{1'b0, tx_high_ff, tx_low_ff[7:4]} + 13'(tx_low_ff[0]);
	// Host relies on lengths being written before the payload
	assign go_now = (loaded_ff >= 13'(RFC_EARLY_START)) ||
		(loaded_ff >= need);
	assign start = ((tx_st_ff == RFC_TX_ARMED) & go_now) |
		((tx_st_ff == RFC_TX_IDLE) & c_txi);

	// Idle, waiting for payload, then sending until frame end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_st_ff <= RFC_TX_IDLE;
			loaded_ff <= 13'h0000;
			tx_cmd_ff <= RFC_CMD_IDLE;
			crc_ff <= RFC_CRC_NONE;
			hdr_ff <= 1'b0;
			rx_crc_ff <= 1'b1;
		end else if (clr) begin
			tx_st_ff <= RFC_TX_IDLE;
			loaded_ff <= 13'h0000;
			tx_cmd_ff <= RFC_CMD_IDLE;
			crc_ff <= RFC_CRC_NONE;
			hdr_ff <= 1'b0;
			rx_crc_ff <= 1'b1;
		end else begin
			case (tx_st_ff)
				RFC_TX_IDLE: begin
					if (c_txd || c_txi) begin
						tx_st_ff <= c_txd ? RFC_TX_ARMED : RFC_TX_RUN;
						loaded_ff <= 13'h0000;
						tx_cmd_ff <= cmd;
						hdr_ff <= cmd == RFC_CMD_TX_HDR;
						rx_crc_ff <= cmd < RFC_CMD_QUERY;
						if (cmd == RFC_CMD_TX_CRC || cmd == RFC_CMD_TX_HDR) begin
							crc_ff <= RFC_CRC_16;
						end else if (cmd == RFC_CMD_QUERY) begin
							crc_ff <= RFC_CRC_5;
						end else begin
							crc_ff <= RFC_CRC_NONE;
						end
					end
				end
				RFC_TX_ARMED: begin
					if (go_now) begin
						tx_st_ff <= RFC_TX_RUN;
					end else if (push_host) begin
						loaded_ff <= loaded_ff + 13'h0001;
					end
				end
				RFC_TX_RUN: begin
					if (tx_eof_in) begin
						tx_st_ff <= RFC_TX_IDLE;
					end
				end
				default: begin
					tx_st_ff <= RFC_TX_IDLE;
				end
			endcase
		end
	end

	// Frame parameters frozen at start; partial bits masked by the flag
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_start_ff <= 1'b0;
			tx_count_ff <= 12'h000;
			part_flag_ff <= 1'b0;
			part_bits_ff <= 3'h0;
		end else begin
			tx_start_ff <= start & ~clr;
			if (clr) begin
				tx_count_ff <= 12'h000;
				part_flag_ff <= 1'b0;
				part_bits_ff <= 3'h0;
			end else if (start) begin
				tx_count_ff <= {tx_high_ff, tx_low_ff[7:4]};
				part_flag_ff <= tx_low_ff[0];
				part_bits_ff <= tx_low_ff[0] ? tx_low_ff[3:1] : 3'h0;
			end
		end
	end

	// Byte register toward the coder, refilled as it is consumed
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff <= 8'h00;
		end else if (clr) begin
			tx_valid_ff <= 1'b0;
		end else if (pop_tx) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= mem_ff[rd_ptr_ff];
		end else if (tx_data_ready_in) begin
			tx_valid_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Read decode and read channel
	logic [5:0] rd_idx;
	logic [7:0] stat_byte, state_byte, rd_byte;
	logic rd_ok;

	assign rd_idx = s_axi_araddr_in[7:2];
	assign stat_byte = {
		rx_active_in & (count_ff >= CW'(RFC_HI_LEVEL)),
		(tx_st_ff == RFC_TX_RUN) & (count_ff <= CW'(RFC_LO_LEVEL)),
		ovf_ff,
		5'(count_ff)};
	assign state_byte = {4'h0, tx_st_ff == RFC_TX_RUN,
		tx_st_ff == RFC_TX_ARMED, pll_aux_ff, en_lvl_ff};
	// Low length register reads back only received bit count
	assign rd_byte =
		(rd_idx == RFC_IDX_FIFO_STAT) ? stat_byte :
		(rd_idx == RFC_IDX_TX_LEN_HIGH) ? tx_high_ff :
		(rd_idx == RFC_IDX_TX_LEN_LOW) ? {3'h0, rx_bits_ff} :
		(rd_idx == RFC_IDX_FIFO_DATA) ? (empty ? 8'h00 : mem_ff[rd_ptr_ff]) :
		(rd_idx == RFC_IDX_ADC_VAL) ? adc_val_ff :
		(rd_idx == RFC_IDX_CTRL) ? {5'h00, msel_ff} :
		(rd_idx == RFC_IDX_STATE) ? state_byte : 8'h00;
	assign rd_ok = (rd_idx >= RFC_IDX_FIFO_STAT && rd_idx <= RFC_IDX_STATE) ||
		(rd_idx == RFC_IDX_ADC_VAL);

	// Data is captured at the address edge, so a FIFO read pops once
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RFC_RESP_OKAY;
		end else if (ar_take) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte};
			rresp_ff <= rd_ok ? RFC_RESP_OKAY : RFC_RESP_SLVERR;
		end else if (r_done) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign s_axi_awready_out = awready_ff;
	assign s_axi_wready_out = wready_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_arready_out = arready_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rdata_out = rdata_ff;
	assign s_axi_rresp_out = rresp_ff;
	assign tx_start_out = tx_start_ff;
	assign tx_cmd_out = tx_cmd_ff;
	assign tx_crc_out = crc_ff;
	assign tx_header_exp_out = hdr_ff;
	assign rx_crc_check_out = rx_crc_ff;
	assign tx_byte_count_out = tx_count_ff;
	assign tx_partial_flag_out = part_flag_ff;
	assign tx_partial_bits_out = part_bits_ff;
	assign tx_data_out = tx_data_ff;
	assign tx_data_valid_out = tx_valid_ff;
	assign pll_aux_sel_out = pll_aux_ff;
	assign adc_start_out = adc_start_ff;
	assign adc_msel_out = msel_ff;
	assign fifo_clear_out = fifo_clr_ff;
	assign soft_init_out = soft_ff;

endmodule : rfc_fifo_cmd

// File: core/rfc_pkg.sv
// Constants and types for the reader FIFO and direct-command unit.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
package rfc_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] RFC_IDX_ADC_VAL = 6'h19;
	localparam logic [5:0] RFC_IDX_FIFO_STAT = 6'h1c;
	localparam logic [5:0] RFC_IDX_TX_LEN_HIGH = 6'h1d;
	localparam logic [5:0] RFC_IDX_TX_LEN_LOW = 6'h1e;
	localparam logic [5:0] RFC_IDX_FIFO_DATA = 6'h1f;
	localparam logic [5:0] RFC_IDX_CMD = 6'h20;
	localparam logic [5:0] RFC_IDX_CTRL = 6'h21;
	localparam logic [5:0] RFC_IDX_STATE = 6'h22;

	// ==========================================================
	// Field positions and reset values
	localparam int RFC_STAT_HI_BIT = 7;
	localparam int RFC_STAT_LO_BIT = 6;
	localparam int RFC_STAT_OVF_BIT = 5;
	localparam int RFC_CMD_BIT = 7;
	localparam logic [7:0] RFC_REG_RESET = 8'h00;
	localparam logic [2:0] RFC_MSEL_RESET = 3'h0;

	// ==========================================================
	// FIFO sizing and thresholds
	localparam int RFC_FIFO_DEPTH = 24;
	localparam int RFC_HI_LEVEL = 18;
	localparam int RFC_LO_LEVEL = 6;
	localparam int RFC_EARLY_START = 3;
	localparam int RFC_QUERY_BYTES = 2;

	// ==========================================================
	// Direct command codes
	localparam logic [7:0] RFC_CMD_IDLE = 8'h80;
	localparam logic [7:0] RFC_CMD_SOFT_INIT = 8'h83;
	localparam logic [7:0] RFC_CMD_HOP_MAIN = 8'h84;
	localparam logic [7:0] RFC_CMD_HOP_AUX = 8'h85;
	localparam logic [7:0] RFC_CMD_ADC = 8'h87;
	localparam logic [7:0] RFC_CMD_FIFO_RST = 8'h8f;
	localparam logic [7:0] RFC_CMD_TX_CRC = 8'h90;
	localparam logic [7:0] RFC_CMD_TX_HDR = 8'h91;
	localparam logic [7:0] RFC_CMD_TX_NOCRC = 8'h92;
	localparam logic [7:0] RFC_CMD_QUERY = 8'h98;
	localparam logic [7:0] RFC_CMD_QREP = 8'h99;
	localparam logic [7:0] RFC_CMD_REQRN = 8'h9f;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RFC_RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {RFC_CRC_NONE, RFC_CRC_16, RFC_CRC_5} rfc_crc_e;
	typedef enum logic [1:0] {RFC_TX_IDLE, RFC_TX_ARMED, RFC_TX_RUN} rfc_tx_e;

endpackage : rfc_pkg

// File: tb/rfc_coder_model.sv
// Coder and ADC stand-in.
// Assumes the same clock; stall_in holds the coder.
`timescale 1ns/1ps
module rfc_coder_model (
	input logic clk_in,
	input logic rstn_in,
	input logic stall_in,
	input logic tx_start_in,
	input logic tx_valid_in,
	output logic tx_ready_out,
	output logic tx_eof_out,
	input logic adc_start_in,
	input logic [2:0] adc_msel_in,
	output logic [7:0] adc_result_out,
	output logic adc_done_out
);
	logic run_ff;
	logic [4:0] idle_ff;
	logic [3:0] adc_ff;
	// ============================================================
	// Frame ends after 16 idle cycles
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{run_ff, idle_ff, adc_ff, tx_eof_out, adc_done_out} <= '0;
			tx_ready_out <= 1'b0;
			adc_result_out <= 8'h00;
		end else begin
			tx_ready_out <= !stall_in;
			tx_eof_out <= run_ff && idle_ff == 5'h10;
			idle_ff <= (tx_start_in || tx_valid_in) ? 5'h0 : idle_ff + 5'h1;
			run_ff <= tx_start_in || (run_ff && idle_ff != 5'h10);
			adc_ff <= adc_start_in ? 4'h8 : adc_ff - 4'(adc_ff != 4'h0);
			adc_done_out <= adc_ff == 4'h1;
			// Result toggles until due
			adc_result_out <= adc_ff == 4'h1 ? {5'h08, adc_msel_in} :
				~adc_result_out;
		end
	end
endmodule : rfc_coder_model

// File: tb/rfc_fifo_cmd_assertions.sv
// Bus and frame-start checks of rfc_fifo_cmd.
// Assumes one clock, rstn_in active low.
`timescale 1ns/1ps
module rfc_fifo_cmd_assertions (
	input logic clk_in,
	input logic rstn_in,
	input logic s_axi_awvalid_in,
	input logic s_axi_awready_out,
	input logic s_axi_wvalid_in,
	input logic s_axi_wready_out,
	input logic s_axi_bvalid_out,
	input logic s_axi_arvalid_in,
	input logic s_axi_arready_out,
	input logic s_axi_rvalid_out,
	input logic tx_start_out,
	input logic [7:0] tx_cmd_out,
	input rfc_pkg::rfc_crc_e tx_crc_out,
	input logic tx_header_exp_out,
	input logic rx_crc_check_out,
	input logic tx_partial_flag_out,
	input logic [2:0] tx_partial_bits_out
);
	import rfc_pkg::*;
	// ============================================================
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Bus answer latency
	a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
		s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out) else $error("read answer late");
	a_refuse_new: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out) else $error("took early");
	// Frame start
	a_start_pulse: assert property (
		tx_start_out |=> !tx_start_out) else $error("start too long");
	a_crc_kind: assert property (tx_start_out |-> tx_crc_out ==
		((tx_cmd_out == RFC_CMD_TX_CRC || tx_cmd_out == RFC_CMD_TX_HDR) ?
		RFC_CRC_16 : tx_cmd_out == RFC_CMD_QUERY ? RFC_CRC_5 : RFC_CRC_NONE))
		else $error("wrong crc kind");
	a_rx_crc_off: assert property (tx_start_out |->
		rx_crc_check_out == (tx_cmd_out[7:3] != 5'h13))
		else $error("wrong rx crc");
	a_header_bit: assert property (tx_start_out |->
		tx_header_exp_out == (tx_cmd_out == RFC_CMD_TX_HDR))
		else $error("wrong header flag");
	a_partial_zero: assert property (!tx_partial_flag_out |->
		tx_partial_bits_out == 3'h0) else $error("stray partial bits");
endmodule : rfc_fifo_cmd_assertions
bind rfc_fifo_cmd rfc_fifo_cmd_assertions u_chk (.*);

// File: tb/test_rfc_fifo_cmd.sv
// Bench of rfc_fifo_cmd: AXI4-Lite host, framer stimulus.
// Assumes rfc_coder_model as coder and ADC.
`timescale 1ns/1ps
module test_rfc_fifo_cmd;
	import rfc_pkg::*;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
	int n_errors = 0, check_count = 0, n_st = 0, n_eof = 0, s0;
	logic clk_in = 0, rstn_in = 0, en = 0, awv = 0, wv = 0, bry = 0;
	logic arv = 0, rry = 0, rxa = 0, rxv = 0, rxd = 0, stall = 0;
	logic [7:0] awa = 0, ara = 0, rxb = 0, d;
	logic [31:0] wd = 0;
	logic [4:0] rxl = 0;
	logic [1:0] resp;
	logic [7:0] q[$], sent[$];
	localparam logic [5:0] FS = RFC_IDX_FIFO_STAT, FD = RFC_IDX_FIFO_DATA;
	localparam logic [5:0] LH = RFC_IDX_TX_LEN_HIGH, LL = RFC_IDX_TX_LEN_LOW;
	wire awr, wr_r, bv, arr, rv, st, hdr, rxc, pf, tv, trd, eof;
	wire pll, adcs, adcd, fclr, sinit;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] cmd_o, td, adr;
	wire rfc_crc_e crc;
	wire [11:0] cnt;
	wire [2:0] pb, msel;
	rfc_fifo_cmd dut (.clk_in, .rstn_in, .en_in(en), .s_axi_awaddr_in(awa),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr_r), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .tx_start_out(st), .tx_cmd_out(cmd_o),
		.tx_crc_out(crc), .tx_header_exp_out(hdr), .rx_crc_check_out(rxc),
		.tx_byte_count_out(cnt), .tx_partial_flag_out(pf),
		.tx_partial_bits_out(pb), .tx_data_out(td), .tx_data_valid_out(tv),
		.tx_data_ready_in(trd), .tx_eof_in(eof), .rx_active_in(rxa),
		.rx_data_in(rxb), .rx_data_valid_in(rxv), .rx_done_in(rxd),
		.rx_last_bits_in(rxl), .pll_aux_sel_out(pll), .adc_start_out(adcs),
		.adc_msel_out(msel), .adc_result_in(adr), .adc_done_in(adcd),
		.fifo_clear_out(fclr), .soft_init_out(sinit));
	rfc_coder_model model (.clk_in, .rstn_in, .stall_in(stall),
		.tx_start_in(st), .tx_valid_in(tv), .tx_ready_out(trd),
		.tx_eof_out(eof), .adc_start_in(adcs), .adc_msel_in(msel),
		.adc_result_out(adr), .adc_done_out(adcd));
	// ============================================================
	// Clock and frame monitor
	initial forever #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		n_st += st;
		n_eof += eof;
		if (tv && trd) sent.push_back(td);
	end
	// ============================================================
	// Host bus tasks
	task automatic wr(input logic [5:0] i, input logic [7:0] v);
		int n = 0;
		{awa, wd, awv, wv, bry} <= {i, 2'h0, 24'h0, v, 3'h7};
		do begin
			@(posedge clk_in);
			n++;
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!bv && n < 40);
		n_errors += !bv;
		resp = bresp;
		bry <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		int n = 0;
		{ara, arv, rry} <= {i, 2'h0, 2'h3};
		do begin
			@(posedge clk_in);
			n++;
			if (arr) arv <= 1'b0;
		end while (!rv && n < 40);
		n_errors += !rv;
		{resp, d} = {rresp, rdata[7:0]};
		rry <= 1'b0;
		@(posedge clk_in);
		`CHK(d, e)
	endtask : rd
	task automatic cmd(input logic [7:0] c);
		wr(RFC_IDX_CMD, c);
		repeat (3) @(posedge clk_in);
	endtask : cmd
	// Random host bytes, expected order in q
	task automatic fill(input int n);
		repeat (n) begin
			q.push_back(8'($urandom));
			wr(FD, q[$]);
		end
	endtask : fill
	task automatic drain(input int n);
		repeat (n) rd(FD, q.pop_front());
	endtask : drain
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// Expected high length
	function automatic logic [7:0] tx_hi(input int i);
		return i == 3 ? 8'h01 : 8'h00;
	endfunction : tx_hi
	// ============================================================
	// Watchdog
	initial begin
		#500us;
		n_errors++;
		end_of_test();
	end
	// ============================================================
	// Main sequence
	initial begin
		logic [7:0] tc[5] = '{RFC_CMD_TX_CRC, RFC_CMD_TX_HDR,
			RFC_CMD_TX_NOCRC, RFC_CMD_QUERY, RFC_CMD_QREP};
		logic [7:0] tl[5] = '{8'h50, 8'h20, 8'h1b, 8'h20, 8'h00};
		int tn[5] = '{5, 2, 2, 2, 0};
		void'($urandom(79));
		repeat (12) @(posedge clk_in);
		{rstn_in, en} <= 2'h3;
		repeat (6) @(posedge clk_in);
		rd(FS, 8'h00);
		rd(LH, 8'h00);
		rd(6'h3f, 8'h00);
		`CHK(resp, RFC_RESP_SLVERR)
		fill(10);
		drain(10);
		fill(24);
		rd(FS, 8'h18);
		wr(FD, 8'h5a);
		rd(FS, 8'h38);
		drain(24);
		rd(FS, 8'h20);
		cmd(RFC_CMD_FIFO_RST);
		rd(FS, 8'h00);
		$display("test fifo done");
		// Framer fills during reception
		rxa <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			if (i == 17) rd(FS, 8'h11);
			q.push_back(8'($urandom));
			{rxb, rxv} <= {q[$], 1'b1};
			@(posedge clk_in);
			rxv <= 1'b0;
			@(posedge clk_in);
		end
		rd(FS, 8'h92);
		{rxa, rxl, rxd} <= {1'b0, 5'($urandom), 1'b1};
		drain(18);
		rxd <= 1'b0;
		rd(LL, {3'h0, rxl});
		$display("test rx done");
		// Transmit commands 90, 91, 92, 98 and 99; coder held until the level is read
		foreach (tc[i]) begin
			sent.delete();
			stall <= 1'b1;
			wr(LH, tx_hi(i));
			wr(LL, tl[i]);
			s0 = n_st;
			cmd(tc[i]);
			for (int j = 0; j < tn[i]; j++) begin
				if (j < 3) `CHK(n_st, s0)
				fill(1);
			end
			for (int w = 0; w < 20 && n_st == s0; w++) @(posedge clk_in);
			`CHK(n_st, s0 + 1)
			`CHK(cnt, {tx_hi(i), tl[i][7:4]})
			`CHK({pf, pb}, {tl[i][0], tl[i][0] ? tl[i][3:1] : 3'h0})
			// First byte waits in the coder register, not in the FIFO
			rd(FS, {2'h1, 6'(q.size() - (q.size() != 0))});
			stall <= 1'b0;
			s0 = n_eof;
			for (int w = 0; w < 200 && n_eof == s0; w++) @(posedge clk_in);
			foreach (q[k]) `CHK(sent[k], q[k])
			q.delete();
			rd(LH, 8'h00);
			rd(LL, {3'h0, rxl});
		end
		$display("test tx done");
		cmd(RFC_CMD_HOP_AUX);
		cmd(8'h05);
		cmd(RFC_CMD_IDLE);
		`CHK(pll, 1'b1)
		cmd(RFC_CMD_HOP_MAIN);
		`CHK(pll, 1'b0)
		for (int m = 1; m < 4; m++) begin
			wr(RFC_IDX_CTRL, 8'(m));
			cmd(RFC_CMD_ADC);
			`CHK(msel, 3'(m))
			repeat (12) @(posedge clk_in);
			rd(RFC_IDX_ADC_VAL, 8'h40 | 8'(m));
		end
		wr(LH, 8'h55);
		cmd(RFC_CMD_HOP_AUX);
		cmd(RFC_CMD_SOFT_INIT);
		`CHK(pll, 1'b0)
		rd(LH, 8'h00);
		rd(RFC_IDX_CTRL, 8'h00);
		fill(3);
		en <= 1'b0;
		repeat (6) @(posedge clk_in);
		rd(FS, 8'h00);
		en <= 1'b1;
		repeat (6) @(posedge clk_in);
		rd(FS, 8'h00);
		$display("test commands done");
		end_of_test();
	end
endmodule : test_rfc_fifo_cmd
